// ### svd_ctrl.sv
// control, settling timer and detect flag for the supply voltage detector
`timescale 1ns/100ps
`default_nettype none
`include "svd_map.svh"
module svd_ctrl #(
   parameter logic [15:0] SETTLE_CYC = 16'(`SVD_SETTLE_CYC)
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // register port
   input  wire logic [`SVD_ADDR_W-1:0] regAddr,
   input  wire logic [7:0]             regWdata,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output var  logic [7:0]             regRdata,
   // analog front end
   input  wire logic                   cmpBelowAsync,
   input  wire logic                   cmpAboveAsync,
   output var  logic                   detectorPowerOn,
   output var  logic                   extInputSelect,
   output var  logic [3:0]             tripLevelSelect,
   // interrupt and wake
   output var  logic                   detectIrq,
   output var  logic                   wakeRequest
);
   // ****************************************************
   // control register
   // ****************************************************
   svd_pkg::svd_ctrl_t ctrl_reg;
   svd_pkg::svd_state_t state_reg;
   svd_pkg::svd_state_t state_next;
   logic [`SVD_CNT_W-1:0] cnt_reg;
   logic [`SVD_CNT_W-1:0] cnt_next;
   logic flag_reg;
   logic ien_reg;
   logic cmpBelow;
   logic cmpAbove;

   wire selCtrl  = (regAddr == `SVD_OFF_CTRL);
   wire selFlag  = (regAddr == `SVD_OFF_FLAG);
   wire selIen   = (regAddr == `SVD_OFF_IEN);
   wire wrCtrl   = regWrite && selCtrl;
   wire wrFlag   = regWrite && selFlag;
   wire wrIen    = regWrite && selIen;
   // a rising write of the enable bit restarts settling
   wire pwrRise  = wrCtrl && regWdata[`SVD_BIT_PWR] && !ctrl_reg.pwrEn;
   wire stable   = (state_reg == svd_pkg::SVD_ARMED);
   // reset image split into the stored fields; the stable bit is not stored
   localparam logic [7:0] CTRL_RST = `SVD_CTRL_RST;
   localparam svd_pkg::svd_ctrl_t CTRL_RST_F = svd_pkg::svd_ctrl_t'(
      {CTRL_RST[`SVD_BIT_DIR], CTRL_RST[`SVD_BIT_PWR],
       CTRL_RST[`SVD_LVL_HI:`SVD_LVL_LO]});
   // a control write decides the enable seen in this cycle
   wire pwrOff   = wrCtrl ? !regWdata[`SVD_BIT_PWR] : !ctrl_reg.pwrEn;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= CTRL_RST_F;
      end else if (wrCtrl) begin
         // stable bit and bit 6 are not writable
         ctrl_reg.dirRise   <= regWdata[`SVD_BIT_DIR];
         ctrl_reg.pwrEn     <= regWdata[`SVD_BIT_PWR];
         ctrl_reg.tripLevel <= regWdata[`SVD_LVL_HI:`SVD_LVL_LO];
      end
   end

   // ****************************************************
   // comparator synchronisers
   // ****************************************************
   svd_sync u_syncBelow (
      .clk     (clk),
      .arst_n  (arst_n),
      .asyncIn (cmpBelowAsync),
      .syncOut (cmpBelow)
   );

   svd_sync u_syncAbove (
      .clk     (clk),
      .arst_n  (arst_n),
      .asyncIn (cmpAboveAsync),
      .syncOut (cmpAbove)
   );

   // ****************************************************
   // settling sequencer
   // ****************************************************
   wire settleDone = (cnt_reg >= SETTLE_CYC - 16'h0001);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         svd_pkg::SVD_OFF: begin
            cnt_next = '0;
            if (pwrRise) begin
               state_next = svd_pkg::SVD_SETTLING;
            end
         end
         svd_pkg::SVD_SETTLING: begin
            cnt_next = cnt_reg + 16'h0001;
            if (settleDone) begin
               state_next = svd_pkg::SVD_ARMED;
            end
         end
         svd_pkg::SVD_ARMED: begin
            cnt_next = '0;
         end
         default: begin
            state_next = svd_pkg::SVD_OFF;
            cnt_next   = '0;
         end
      endcase
      // disable always wins and drops the stable bit
      if (pwrOff) begin
         state_next = svd_pkg::SVD_OFF;
         cnt_next   = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= svd_pkg::SVD_OFF;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ****************************************************
   // detect flag
   // ****************************************************
   // comparator trips are only trusted after settling
   wire cmpTrip  = ctrl_reg.dirRise ? cmpAbove : cmpBelow;
   wire event_w  = ctrl_reg.pwrEn && stable && cmpTrip;
   wire flagNext = event_w | (flag_reg & ~(wrFlag & ~regWdata[`SVD_BIT_FLAG]));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= 1'b0;
         ien_reg  <= 1'b0;
      end else begin
         // set wins over a software clear
         flag_reg <= flagNext;
         if (wrIen) begin
            ien_reg <= regWdata[`SVD_BIT_IEN];
         end
      end
   end

   // ****************************************************
   // read port and outputs
   // ****************************************************
   wire [7:0] ctrlRead = {ctrl_reg.dirRise, 1'b0, stable, ctrl_reg.pwrEn,
                          ctrl_reg.tripLevel};
   wire [7:0] flagRead = {5'h00, flag_reg, 2'h0};
   wire [7:0] ienRead  = {5'h00, ien_reg, 2'h0};
   wire [7:0] rdMux    = selCtrl ? ctrlRead :
                         selFlag ? flagRead :
                         selIen  ? ienRead  : 8'h00;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdata        <= 8'h00;
         detectorPowerOn <= 1'b0;
         extInputSelect  <= 1'b0;
         tripLevelSelect <= 4'h0;
         detectIrq       <= 1'b0;
         wakeRequest     <= 1'b0;
      end else begin
         regRdata        <= regRead ? rdMux : 8'h00;
         detectorPowerOn <= ctrl_reg.pwrEn;
         extInputSelect  <= (ctrl_reg.tripLevel == `SVD_LVL_EXT);
         tripLevelSelect <= ctrl_reg.tripLevel;
         detectIrq       <= flagNext && ien_reg;
         // sleep runs on the same clock; wake follows the flag
         wakeRequest     <= flagNext;
      end
   end
endmodule // svd_ctrl
`default_nettype wire

// ### svd_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SVD_MAP_SVH
`define SVD_MAP_SVH
// ****************************************************
// register map
// ****************************************************
`define SVD_ADDR_W       4
`define SVD_OFF_CTRL     4'h0
`define SVD_OFF_FLAG     4'h1
`define SVD_OFF_IEN      4'h2
// ****************************************************
// control fields
// ****************************************************
`define SVD_BIT_DIR      7
`define SVD_BIT_STABLE   5
`define SVD_BIT_PWR      4
`define SVD_LVL_HI       3
`define SVD_LVL_LO       0
`define SVD_BIT_FLAG     2
`define SVD_BIT_IEN      2
`define SVD_CTRL_RST     8'h05
`define SVD_LVL_EXT      4'hf
// ****************************************************
// timing
// ****************************************************
`define SVD_CLK_MHZ      125
`define SVD_SETTLE_US    20
`define SVD_SETTLE_CYC   (`SVD_SETTLE_US * `SVD_CLK_MHZ)
`define SVD_CNT_W        16
`endif

// ### svd_pkg.sv
// types shared by the voltage detect control block
package svd_pkg;
   typedef struct packed {
      logic       dirRise;
      logic       pwrEn;
      logic [3:0] tripLevel;
   } svd_ctrl_t;

   typedef enum logic [1:0] {
      SVD_OFF      = 2'b00,
      SVD_SETTLING = 2'b01,
      SVD_ARMED    = 2'b10
   } svd_state_t;
endpackage

// ### svd_sync.sv
// two-stage synchroniser for the comparator output
`timescale 1ns/100ps
`default_nettype none
module svd_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // data
   input  wire logic asyncIn,
   output var  logic syncOut
);
   logic stage1_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= 1'b0;
         syncOut    <= 1'b0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut    <= stage1_reg;
      end
   end
endmodule // svd_sync
`default_nettype wire

// ### svd_ctrl_sva.sv
// checker for the voltage detect control block
`timescale 1ns/100ps
`default_nettype none
module svd_ctrl_sva (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   // detector side
   input wire logic cmpBelowAsync,
   input wire logic cmpAboveAsync,
   input wire logic detectorPowerOn,
   input wire logic extInputSelect,
   input wire logic [3:0] tripLevelSelect,
   input wire logic detectIrq,
   input wire logic wakeRequest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic dirReg;
   wire ctrlWr = regWrite && regAddr == 4'h0;
   // direction is not on a port, so track it from writes
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) dirReg <= 1'b0;
      else if (ctrlWr) dirReg <= regWdata[7];
   chk_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data not zero");
   chk_level_copy: assert property (ctrlWr |-> ##2 tripLevelSelect == $past(regWdata[3:0], 2))
      else $error("level not taken");
   chk_power_copy: assert property (ctrlWr |-> ##2 detectorPowerOn == $past(regWdata[4], 2))
      else $error("power bit not taken");
   chk_ext_select: assert property (extInputSelect == (tripLevelSelect == 4'hf))
      else $error("external select wrong");
   chk_irq_gate: assert property (detectIrq |-> wakeRequest)
      else $error("request without flag");
   chk_off_quiet: assert property ($rose(wakeRequest) |-> $past(detectorPowerOn))
      else $error("flag while off");
   chk_settle_quiet: assert property ($rose(detectorPowerOn) |-> !$rose(wakeRequest) [*8])
      else $error("flag while settling");
   chk_flag_cause: assert property ($rose(wakeRequest) |-> (dirReg ? $past(cmpAboveAsync, 3) : $past(cmpBelowAsync, 3)))
      else $error("flag without crossing");
   cover property ($rose(wakeRequest));
   cover property ($rose(detectIrq));
   cover property (extInputSelect);
endmodule // svd_ctrl_sva
bind svd_ctrl svd_ctrl_sva i_chk (.clk, .arst_n, .regAddr, .regWdata,
   .regWrite, .regRead, .regRdata, .cmpBelowAsync, .cmpAboveAsync,
   .detectorPowerOn, .extInputSelect, .tripLevelSelect, .detectIrq,
   .wakeRequest);
`default_nettype wire

// ### svd_ctrl_tb.sv
// self-checking bench for the voltage detect control block
`timescale 1ns/100ps
`default_nettype none
module svd_ctrl_tb;
   logic clk, arst_n, regWrite, regRead, cmpBelowAsync, cmpAboveAsync;
   logic detectorPowerOn, extInputSelect, detectIrq, wakeRequest;
   logic [3:0] regAddr, tripLevelSelect;
   logic [7:0] regWdata, regRdata;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   // control write beside expected readback
   logic [7:0] rows [6][2] = '{'{8'hff, 8'h9f}, '{8'h4a, 8'h0a},
      '{8'h80, 8'h80}, '{8'h2f, 8'h0f}, '{8'h11, 8'h11}, '{8'h07, 8'h07}};
   svd_ctrl #(.SETTLE_CYC(16'h0008)) i_dut (.clk, .arst_n, .regAddr,
      .regWdata, .regWrite, .regRead, .regRdata, .cmpBelowAsync,
      .cmpAboveAsync, .detectorPowerOn, .extInputSelect, .tripLevelSelect,
      .detectIrq, .wakeRequest);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ****************
   // tasks
   // ****************
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk("regRdata", e, regRdata);
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   // ****************
   // sequence
   // ****************
   initial begin
      arst_n = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      {regWrite, regRead, cmpBelowAsync, cmpAboveAsync} = 4'h0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h0, 8'h05);
      foreach (rows[i]) begin
         wr(4'h0, rows[i][0]);
         // trip and power outputs are registered copies of the control register, ext is a registered decode of the level
         repeat (2) @(negedge clk);
         chk("trip", 8'(rows[i][1][3:0]), 8'(tripLevelSelect));
         chk("power", 8'(rows[i][1][4]), 8'(detectorPowerOn));
         chk("ext", 8'(rows[i][1][3:0] == 4'hf), 8'(extInputSelect));
         rd(4'h0, rows[i][1]);
      end
      wr(4'h0, 8'h15);
      cmpBelowAsync <= 1'b1;
      repeat (6) @(negedge clk);
      chk("wake", 8'h00, 8'(wakeRequest));
      repeat (10) @(negedge clk);
      chk("wake", 8'h01, 8'(wakeRequest));
      chk("irq", 8'h00, 8'(detectIrq));
      rd(4'h0, 8'h35);
      rd(4'h1, 8'h04);
      wr(4'h2, 8'h04);
      repeat (2) @(negedge clk);
      chk("irq", 8'h01, 8'(detectIrq));
      rd(4'h2, 8'h04);
      @(posedge clk);
      cmpBelowAsync <= 1'b0;
      repeat (4) @(posedge clk);
      wr(4'h1, 8'hfb);
      repeat (2) @(negedge clk);
      chk("wake", 8'h00, 8'(wakeRequest));
      chk("irq", 8'h00, 8'(detectIrq));
      wr(4'h0, 8'h95);
      cmpBelowAsync <= 1'b1;
      repeat (6) @(negedge clk);
      chk("wake", 8'h00, 8'(wakeRequest));
      @(posedge clk);
      cmpAboveAsync <= 1'b1;
      repeat (5) @(negedge clk);
      chk("wake", 8'h01, 8'(wakeRequest));
      wr(4'h0, 8'h65);
      rd(4'h0, 8'h05);
      wr(4'h1, 8'h00);
      repeat (6) @(negedge clk);
      chk("wake", 8'h00, 8'(wakeRequest));
      wr(4'h9, 8'hff);
      rd(4'h7, 8'h00);
      rd(4'h0, 8'h05);
      wr(4'h0, 8'h9a);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h0, 8'h05);
      chk("power", 8'h00, 8'(detectorPowerOn));
      wrap_up();
   end
endmodule // svd_ctrl_tb
`default_nettype wire
